// File: logic/psf_filter.sv
// Ingress filter: per-port source-address lock plus storm control.
// Assumes one frame header per cycle from the ports, fabric takes a verdict per frame.
// Notes on behaviour
// - Secured port learns the first source address seen as authorized
// - Secured port drops frames whose source differs from authorized
// - Disabling security erases the address and accepts everyone
// - Security off on all ports after reset
// - Fast Ethernet ports never apply source-address security
// - Ports are numbered 1 to 14
// - Only received broadcast and multicast frames are rate limited
// - One module-wide enable supervises every port at once
// - Over 20 flood frames in 100 ms suspends that port's flooding
// - Suspension ends once rate falls below 200 per second
// - Suspension ends once average rate is paid back below 200
// - Limit is per input port, not per output
// - Storm control off forwards everything normally
// - Storm control off after reset
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
module psf_filter #(
    parameter int NUM_PORTS = psf_pkg::NUM_PORTS,
    parameter int INTERVAL_CYC = psf_pkg::INTERVAL_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic frm_valid,
    input wire logic [3:0] frm_port,
    input wire logic [psf_pkg::MAC_W-1:0] frm_src,
    input wire logic [psf_pkg::MAC_W-1:0] frm_dst,
    output logic fwd_valid,
    output logic fwd_pass,
    output logic [3:0] fwd_port,
    output logic irq,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic storm_en;
    logic [NUM_PORTS-1:0] sec_en;
    logic [NUM_PORTS-1:0] fast_port;
    logic [NUM_PORTS-1:0] locked;
    logic [psf_pkg::MAC_W-1:0] auth_addr [NUM_PORTS];
    logic [NUM_PORTS-1:0] suspended;
    logic [psf_pkg::ST_W-1:0] status;
    logic [psf_pkg::ST_W-1:0] mask;
    logic [31:0] tick_cnt;
    logic interval_tick;

    // Port numbers 1..14 map to index 0..13
    function automatic logic [NUM_PORTS-1:0] port_onehot(input logic [3:0] num);
        port_onehot = '0;
        if (num >= 4'h1 && 32'(num) <= NUM_PORTS) begin
            port_onehot[num - 4'h1] = 1'b1;
        end
    endfunction : port_onehot

    wire [NUM_PORTS-1:0] frm_sel = frm_valid ? port_onehot(frm_port) : '0;
    wire frm_legal = |frm_sel;
    wire [3:0] frm_idx = frm_port - 4'h1;
    // Group bit of the destination covers broadcast as well as multicast
    wire frm_flood = frm_dst[40];
    wire [NUM_PORTS-1:0] sec_active = sec_en & ~fast_port;
    wire frm_sec = frm_legal && sec_active[frm_idx];
    wire frm_locked = frm_legal && locked[frm_idx];
    wire sec_drop = frm_sec && frm_locked && (auth_addr[frm_idx] != frm_src);
    wire sec_learn = frm_sec && !frm_locked;
    wire storm_drop = frm_legal && frm_flood && suspended[frm_idx];
    wire pass_now = frm_legal && !sec_drop && !storm_drop;

    assign interval_tick = (tick_cnt == 32'(INTERVAL_CYC - 1));
    always_ff @(posedge aclk) begin
        if (!aresetn || !storm_en) begin
            tick_cnt <= '0;
        end else if (ce) begin
            tick_cnt <= interval_tick ? '0 : tick_cnt + 32'h1;
        end
    end

    genvar gp;
    generate
        for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
            psf_storm_port u_storm (
                .aclk(aclk),
                .aresetn(aresetn),
                .ce(ce),
                .enable(storm_en),
                .interval_tick(interval_tick),
                .flood_seen(frm_sel[gp] && frm_flood),
                .suspended(suspended[gp])
            );
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    locked[gp] <= 1'b0;
                    auth_addr[gp] <= '0;
                end else if (ce && !sec_active[gp]) begin
                    locked[gp] <= 1'b0;
                    auth_addr[gp] <= '0;
                end else if (ce && sec_learn && frm_sel[gp]) begin
                    locked[gp] <= 1'b1;
                    auth_addr[gp] <= frm_src;
                end
            end
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fwd_valid <= 1'b0;
            fwd_pass <= 1'b0;
            fwd_port <= 4'h0;
        end else if (ce) begin
            fwd_valid <= frm_valid;
            fwd_pass <= pass_now;
            fwd_port <= frm_port;
        end
    end

    // AXI4-Lite slave: address and data accepted in either order
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_go = aw_held && w_held && !s_axi_bvalid;
    wire wr_ctrl = wr_go && aw_addr == psf_pkg::REG_CTRL && w_strb[0];
    wire wr_sec = wr_go && aw_addr == psf_pkg::REG_SEC_EN;
    wire wr_fast = wr_go && aw_addr == psf_pkg::REG_FAST;
    wire wr_mask = wr_go && aw_addr == psf_pkg::REG_MASK && w_strb[0];
    wire wr_hit = aw_addr == psf_pkg::REG_CTRL || aw_addr == psf_pkg::REG_SEC_EN ||
        aw_addr == psf_pkg::REG_FAST || aw_addr == psf_pkg::REG_MASK;
    wire [31:0] sec_merge = 32'({w_strb[1] ? w_data[15:8] : {2'h0, sec_en[13:8]},
        w_strb[0] ? w_data[7:0] : sec_en[7:0]}) & 32'h3FFF;
    wire [31:0] fast_merge = 32'({w_strb[1] ? w_data[15:8] : {2'h0, fast_port[13:8]},
        w_strb[0] ? w_data[7:0] : fast_port[7:0]}) & 32'h3FFF;
    wire rd_go = s_axi_arvalid && s_axi_arready;
    wire rd_status = rd_go && s_axi_araddr == psf_pkg::REG_STATUS;
    wire rd_hit = s_axi_araddr <= psf_pkg::REG_MASK && s_axi_araddr[1:0] == 2'h0;
    logic [31:0] rd_mux;
    always_comb begin
        case (s_axi_araddr)
            psf_pkg::REG_CTRL: rd_mux = {31'h0, storm_en};
            psf_pkg::REG_SEC_EN: rd_mux = 32'(sec_en);
            psf_pkg::REG_FAST: rd_mux = 32'(fast_port);
            psf_pkg::REG_LOCKED: rd_mux = 32'(locked);
            psf_pkg::REG_SUSP: rd_mux = 32'(suspended);
            psf_pkg::REG_STATUS: rd_mux = 32'(status);
            psf_pkg::REG_MASK: rd_mux = 32'(mask);
            default: rd_mux = 32'h0;
        endcase
    end
    logic [NUM_PORTS-1:0] susp_q;
    wire storm_rise = |(suspended & ~susp_q);
    wire [psf_pkg::ST_W-1:0] ev = {sec_learn && ce, storm_rise, sec_drop && ce};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= psf_pkg::RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= psf_pkg::RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? psf_pkg::RESP_OKAY : psf_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            if (rd_go) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_hit ? psf_pkg::RESP_OKAY : psf_pkg::RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Configuration ignores clock enable so software can always reach it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sec_en <= '0;
            storm_en <= 1'b0;
            fast_port <= psf_pkg::FAST_RESET;
            mask <= '0;
        end else begin
            if (wr_ctrl) begin
                storm_en <= w_data[psf_pkg::CTRL_STORM_EN];
            end
            if (wr_sec) begin
                sec_en <= sec_merge[NUM_PORTS-1:0];
            end
            if (wr_fast) begin
                fast_port <= fast_merge[NUM_PORTS-1:0];
            end
            if (wr_mask) begin
                mask <= w_data[psf_pkg::ST_W-1:0];
            end
        end
    end

    // Set wins over the read that clears
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status <= '0;
            susp_q <= '0;
            irq <= 1'b0;
        end else begin
            susp_q <= suspended;
            status <= (rd_status ? '0 : status) | ev;
            irq <= |(((rd_status ? '0 : status) | ev) & mask);
        end
    end
endmodule : psf_filter

// File: shared/psf_pkg.sv
// Package for the port security and storm filter block.
// Assumes a 50 MHz clock and a 32-bit AXI4-Lite register bus.
package psf_pkg;
    localparam int NUM_PORTS = 14;
    localparam int MAC_W = 48;
    localparam int CLK_HZ = 50000000;
    localparam int INTERVAL_MS = 100;
    localparam int INTERVAL_CYC = CLK_HZ / 1000 * INTERVAL_MS;
    localparam int STORM_LIMIT = 20;
    localparam int CNT_W = 16;
    localparam int DEBT_W = 16;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_SEC_EN = 8'h04;
    localparam logic [7:0] REG_FAST = 8'h08;
    localparam logic [7:0] REG_LOCKED = 8'h0C;
    localparam logic [7:0] REG_SUSP = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_MASK = 8'h18;
    localparam int CTRL_STORM_EN = 0;
    localparam logic [13:0] FAST_RESET = 14'h3000;
    // Status bit positions
    localparam int ST_SEC_DROP = 0;
    localparam int ST_STORM = 1;
    localparam int ST_LEARN = 2;
    localparam int ST_W = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : psf_pkg

// File: logic/psf_storm_port.sv
// One port's broadcast and multicast rate limiter.
// Assumes interval_tick is common to all ports and one cycle long.
`timescale 1ns/1ps
module psf_storm_port #(
    parameter int LIMIT = psf_pkg::STORM_LIMIT
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic enable,
    input wire logic interval_tick,
    input wire logic flood_seen,
    output logic suspended
);
    logic [psf_pkg::CNT_W-1:0] count;
    logic [psf_pkg::DEBT_W-1:0] debt;
    logic [psf_pkg::CNT_W-1:0] next_count;
    logic [psf_pkg::DEBT_W-1:0] next_debt;
    logic next_suspended;
    logic over;
    logic slow;

    assign over = count > psf_pkg::CNT_W'(LIMIT);
    assign slow = count < psf_pkg::CNT_W'(LIMIT);

    always_comb begin
        next_count = count;
        next_debt = debt;
        next_suspended = suspended;
        if (!enable) begin
            next_count = '0;
            next_debt = '0;
            next_suspended = 1'b0;
        end else if (interval_tick) begin
            next_count = flood_seen ? psf_pkg::CNT_W'(1) : '0;
            if (!suspended && over) begin
                // Over twenty suspends; excess becomes debt in intervals
                next_suspended = 1'b1;
                // Rounded up so the average over the whole suspension stays at or under the limit
                next_debt = psf_pkg::DEBT_W'((32'(count) + LIMIT - 1) / LIMIT) - 1'b1;
            end else if (suspended) begin
                if (debt != '0) begin
                    next_debt = debt - 1'b1;
                end
                if (slow || debt <= psf_pkg::DEBT_W'(1)) begin
                    next_suspended = 1'b0;
                    next_debt = '0;
                end
            end
        end else if (flood_seen && count != '1) begin
            next_count = count + 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= '0;
            debt <= '0;
            suspended <= 1'b0;
        end else if (ce) begin
            count <= next_count;
            debt <= next_debt;
            suspended <= next_suspended;
        end
    end
endmodule : psf_storm_port

// File: tb/psf_filter_properties.sv
// Port-level checks for the ingress filter.
// Sees only the top module's ports; bound into every psf_filter.
`timescale 1ns/1ps
module psf_filter_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic frm_valid,
    input wire logic [3:0] frm_port,
    input wire logic fwd_valid,
    input wire logic fwd_pass,
    input wire logic [3:0] fwd_port,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire logic taken = frm_valid && ce;
    fwd_follows_a: assert property (taken |=> fwd_valid && fwd_port == $past(frm_port))
        else $error("verdict missing after frame");
    fwd_idle_a: assert property (ce && !frm_valid |=> !fwd_valid)
        else $error("verdict without frame");
    ce_hold_a: assert property (!ce |=> $stable(fwd_valid) && $stable(fwd_pass) && $stable(fwd_port))
        else $error("verdict moved while frozen");
    bad_port_a: assert property (taken && (frm_port == 4'h0 || frm_port > 4'hE) |=> !fwd_pass)
        else $error("bad port passed");
    aw_refuse_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("second write address taken");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response held too long");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data late");
    r_done_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
endmodule : psf_filter_properties

bind psf_filter psf_filter_properties u_prop (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .frm_valid(frm_valid), .frm_port(frm_port), .fwd_valid(fwd_valid), .fwd_pass(fwd_pass),
    .fwd_port(fwd_port), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// File: tb/psf_station.sv
// Stations on the switch ports: one frame header per call.
// Assumes the caller runs on the filter's clock.
`timescale 1ns/1ps
module psf_station (
    input wire logic aclk,
    output logic frm_valid,
    output logic [3:0] frm_port,
    output logic [psf_pkg::MAC_W-1:0] frm_src,
    output logic [psf_pkg::MAC_W-1:0] frm_dst
);
    initial begin
        frm_valid = 1'b0;
        frm_port = 4'h0;
        frm_src = '0;
        frm_dst = '0;
    end
    task automatic send(input logic [3:0] p, input logic [47:0] s, input logic [47:0] d);
        @(posedge aclk);
        frm_valid <= 1'b1;
        frm_port <= p;
        frm_src <= s;
        frm_dst <= d;
        @(posedge aclk);
        frm_valid <= 1'b0;
        // Stale fields inverted so a late sample cannot match
        frm_src <= ~s;
        frm_dst <= ~d;
    endtask : send
endmodule : psf_station

// File: tb/psf_filter_bench.sv
// Self-checking bench for the ingress filter over AXI4-Lite and frames.
// Assumes a shortened interval so storm windows last 200 cycles.
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module psf_filter_bench;
    logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [1:0] bresp, rresp, rsp, wrsp;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, fwd_valid, fwd_pass, irq, fv;
    logic [3:0] fport, fwd_port;
    logic [47:0] fsrc, fdst;
    int err_total = 0, tests_run = 0;
    int drops = 0, seen_back = 0;
    localparam logic [47:0] SA = 48'h0000_0000_0A01, SB = 48'h0000_0000_0B02;
    localparam logic [47:0] UNI = 48'h0000_0000_0001, MC = 48'h0100_0000_0000;
    always #10 aclk = ~aclk;
    psf_station sta (.aclk(aclk), .frm_valid(fv), .frm_port(fport), .frm_src(fsrc),
        .frm_dst(fdst));
    psf_filter #(.INTERVAL_CYC(200)) dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .frm_valid(fv), .frm_port(fport), .frm_src(fsrc), .frm_dst(fdst),
        .fwd_valid(fwd_valid), .fwd_pass(fwd_pass), .fwd_port(fwd_port), .irq(irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    task automatic complete_run;
        $display("tests_run=%0d err_total=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : complete_run
    task automatic timed_out;
        err_total++;
        complete_run();
    endtask : timed_out
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        for (n = 0; n < 50 && !(bvalid && bready); n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        wrsp = bresp;
        bready <= 1'b0;
        if (n == 50) timed_out();
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        int n;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (n = 0; n < 50 && !(rvalid && rready); n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end
        rd = rdata; rsp = rresp; rready <= 1'b0;
        if (n == 50) timed_out();
    endtask : rdr
    task automatic wait_reg(input logic [7:0] a, input logic [31:0] v);
        int n;
        rdr(a);
        for (n = 0; n < 400 && rd !== v; n++) rdr(a);
        if (n == 400) timed_out();
    endtask : wait_reg
    task automatic frm(input logic [3:0] p, input logic [47:0] s, d, input logic e);
        sta.send(p, s, d);
        #1;
        `CHK(fwd_valid, 1'b1)
        `CHK(fwd_pass, e)
        `CHK(fwd_port, p)
    endtask : frm
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(psf_pkg::REG_SEC_EN); `CHK(rd, 32'h0)
        rdr(psf_pkg::REG_CTRL); `CHK(rd, 32'h0)
        rdr(psf_pkg::REG_FAST); `CHK(rd, 32'h3000)
        rdr(8'h1C); `CHK(rsp, psf_pkg::RESP_SLVERR)
        frm(4'h0, SA, UNI, 1'b0);
        frm(4'hF, SA, UNI, 1'b0);
        wr(psf_pkg::REG_MASK, 32'h1);
        `CHK(wrsp, psf_pkg::RESP_OKAY)
        wr(psf_pkg::REG_SEC_EN, 32'h3FFF);
        frm(4'h1, SA, UNI, 1'b1);
        frm(4'h1, SB, UNI, 1'b0);
        frm(4'h1, SA, MC, 1'b1);
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'b1)
        rdr(psf_pkg::REG_STATUS); `CHK(rd, 32'h5)
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'b0)
        frm(4'hE, SA, UNI, 1'b1);
        frm(4'hE, SB, UNI, 1'b1);
        // Frozen clock enable: no verdict and no learning on secured port 2
        @(posedge aclk);
        ce <= 1'b0;
        sta.send(4'h2, SB, UNI);
        #1;
        `CHK(fwd_valid, 1'b0)
        @(posedge aclk);
        ce <= 1'b1;
        rdr(psf_pkg::REG_LOCKED); `CHK(rd, 32'h1)
        wr(psf_pkg::REG_LOCKED, 32'h0);
        `CHK(wrsp, psf_pkg::RESP_SLVERR)
        wr(psf_pkg::REG_SEC_EN, 32'h0);
        frm(4'h1, SB, UNI, 1'b1);
        wr(psf_pkg::REG_SEC_EN, 32'h1);
        frm(4'h1, SB, UNI, 1'b1);
        wr(psf_pkg::REG_SEC_EN, 32'h0);
        for (int i = 0; i < 25; i++) frm(4'h2, SA, 48'hFFFF_FFFF_FFFF, 1'b1);
        wr(psf_pkg::REG_CTRL, 32'h1);
        for (int i = 0; i < 21; i++) begin
            frm(4'h3, SA, MC, 1'b1);
            frm(4'h6, SB, MC, 1'b1);
        end
        // Ports 3 and 6 both over the limit in the same aligned window
        wait_reg(psf_pkg::REG_SUSP, 32'h24); `CHK(rd, 32'h24)
        rdr(psf_pkg::REG_STATUS); `CHK(rd, 32'h6)
        frm(4'h3, SA, MC, 1'b0);
        frm(4'h3, SA, UNI, 1'b1);
        frm(4'h5, SA, MC, 1'b1);
        wait_reg(psf_pkg::REG_SUSP, 32'h0); `CHK(rd, 32'h0)
        frm(4'h3, SA, MC, 1'b1);
        // Restart the window, then flood port 4 at five times the limit without pause
        wr(psf_pkg::REG_CTRL, 32'h0);
        wr(psf_pkg::REG_CTRL, 32'h1);
        for (int i = 0; i < 1000 && seen_back == 0; i++) begin
            sta.send(4'h4, SA, MC);
            #1;
            `CHK(fwd_valid, 1'b1)
            if (fwd_pass === 1'b0) drops++;
            else if (drops > 0) seen_back = 1;
        end
        // Rate never falls, so resuming needs the average paid back: four windows dropped
        `CHK(seen_back, 1)
        `CHK(drops > 350, 1'b1)
        complete_run();
    end
endmodule : psf_filter_bench
